// ### spr_defs.vh
// Constants of the serial port host register block.
// Included by spr_fifo.v users and spr_regs.v; definitions only.
`ifndef SPR_DEFS_VH
`define SPR_DEFS_VH

// Register offsets (A2..A0)
`define SPR_OFS_DATA      3'h0
`define SPR_OFS_IER       3'h1
`define SPR_OFS_IIR_FCR   3'h2
`define SPR_OFS_LCR       3'h3
`define SPR_OFS_MCR       3'h4
`define SPR_OFS_LSR       3'h5
`define SPR_OFS_MSR       3'h6

// Interrupt enable fields
`define SPR_IER_RDA       0
`define SPR_IER_THRE      1
`define SPR_IER_RLS       2
`define SPR_IER_MSI       3
`define SPR_IER_MASK      8'h0F

// FIFO control fields
`define SPR_FCR_EN        0
`define SPR_FCR_RXCLR     1
`define SPR_FCR_TXCLR     2
`define SPR_FCR_TRIG_HI   7
`define SPR_FCR_TRIG_LO   6

// Trigger levels in bytes
`define SPR_TRIG_0        5'h01
`define SPR_TRIG_1        5'h04
`define SPR_TRIG_2        5'h08
`define SPR_TRIG_3        5'h0E

// Identification codes, bits 3..0
`define SPR_ID_NONE       4'h1
`define SPR_ID_RLS        4'h6
`define SPR_ID_RDA        4'h4
`define SPR_ID_CTO        4'hC
`define SPR_ID_THRE       4'h2
`define SPR_ID_MSI        4'h0

// Character timeout in character times
`define SPR_CTO_CHARS     3'h4

// Reset values
`define SPR_RST_IER       8'h00
`define SPR_RST_FCR       8'h00
`define SPR_RST_BYTE      8'h00

// FIFO geometry
`define SPR_FIFO_W        8
`define SPR_FIFO_D        4
`define SPR_FIFO_AW       2

`endif

// ### spr_fifo.v
// Small synchronous FIFO with valid and ready on both sides.
// Assumes one clock; clear_in empties it without touching the data.
`timescale 1ns/1ps
module spr_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  // Clock and reset
  input  wire             clk_in,
  input  wire             sys_rst_in,
  input  wire             clear_in,
  // Filling side
  input  wire [WIDTH-1:0] in_data_in,
  input  wire             in_valid_in,
  output wire             in_ready_out,
  // Draining side
  output wire [WIDTH-1:0] out_data_out,
  output wire             out_valid_out,
  input  wire             out_ready_in,
  // Fill level
  output wire [AW:0]      count_out
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  wire            push;
  wire            pop;

  // Sized steps keep pointer and count arithmetic at their own widths
  localparam [AW-1:0] PTR_STEP = 1;
  localparam [AW:0]   CNT_STEP = 1;
  localparam [AW:0]   FULL_LVL = DEPTH;

  assign in_ready_out  = (count != FULL_LVL);
  assign out_valid_out = (count != {(AW+1){1'b0}});
  assign out_data_out  = mem[rd_ptr];
  assign count_out     = count;
  assign push = in_valid_in & in_ready_out;
  assign pop  = out_valid_out & out_ready_in;

  // Storage is not reset; only pointers and count matter
  always @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end

  // Pointers and fill count
  always @(posedge clk_in) begin
    if (sys_rst_in || clear_in) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + PTR_STEP;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + PTR_STEP;
      end
      if (push && !pop) begin
        count <= count + CNT_STEP;
      end else if (pop && !push) begin
        count <= count - CNT_STEP;
      end
    end
  end

endmodule

// ### spr_line_peer.sv
// Far end of the serial line: sends frames, collects frames.
// Assumes start, eight data bits, stop, one bit per tick.
`timescale 1ns/1ps
module spr_line_peer (
  // Clock and pacing
  input  wire       clk_in,
  input  wire       tick_in,
  // Serial pins
  input  wire       txd_in,
  output reg        rxd_out,
  // Frames collected
  output reg  [2:0] got_cnt_out
);
  reg [7:0] got [0:3];
  reg [7:0] sh;
  reg [3:0] n;
  reg       busy;
  initial begin
    rxd_out = 1'b1;
    got_cnt_out = 3'h0;
    busy = 1'b0;
    n = 4'h0;
    sh = 8'h00;
  end
  // Lowest bit leaves first; line idles high
  task send(input [7:0] b);
    reg [9:0] f;
    integer k;
    begin
      f = {1'b1, b, 1'b0};
      for (k = 0; k < 10; k = k + 1) begin
        @(posedge clk_in);
        while (!tick_in)
          @(posedge clk_in);
        rxd_out <= f[k];
      end
    end
  endtask
  // Frames rebuilt lowest bit first; unknown line is not a start
  always @(posedge clk_in) begin
    if (tick_in) begin
      if (!busy) begin
        busy <= (txd_in === 1'b0);
        n <= 4'h0;
      end else if (n < 4'h8) begin
        sh <= {txd_in, sh[7:1]};
        n <= n + 4'h1;
      end else begin
        busy <= 1'b0;
        got[got_cnt_out[1:0]] <= sh;
        got_cnt_out <= got_cnt_out + 3'h1;
      end
    end
  end
endmodule

// ### spr_regs.v
// Host register block of one serial port: data, enable, FIFO control and
// prioritized interrupt identification.
// Assumes a synchronous 8-bit host bus strobe per access, and neighbouring
// line, modem and baud logic that feed the status events below.
`timescale 1ns/1ps
`include "spr_defs.vh"
module spr_regs (
  // Clock and reset
  input  wire       clk_in,
  input  wire       sys_rst_in,
  // Host bus
  input  wire [2:0] addr_in,
  input  wire       rd_in,
  input  wire       wr_in,
  input  wire [7:0] wdata_in,
  output reg  [7:0] rdata_out,
  // Settings from line and modem control neighbours
  input  wire       divisor_access_bit_in,
  input  wire       irq_output_gate_in,
  input  wire [7:0] divisor_low_in,
  input  wire [7:0] divisor_high_in,
  input  wire [7:0] aux_rdata_in,
  // Status events from the line and modem neighbours
  input  wire       line_error_in,
  input  wire       modem_change_in,
  input  wire       char_tick_in,
  // Divisor write strobes
  output wire       divisor_low_wr_out,
  output wire       divisor_high_wr_out,
  // Serial line
  input  wire       rxd_in,
  input  wire       bit_tick_in,
  output reg        txd_out,
  // Interrupt
  output wire       irq_out,
  output wire       irq_oe_out
);

  localparam ST_IDLE  = 3'b001;
  localparam ST_SHIFT = 3'b010;
  localparam ST_STOP  = 3'b100;

  // Trigger level decode, used for compare
  function [4:0] spr_trig;
    input [1:0] sel;
    begin
      case (sel)
        2'b00:   spr_trig = `SPR_TRIG_0;
        2'b01:   spr_trig = `SPR_TRIG_1;
        2'b10:   spr_trig = `SPR_TRIG_2;
        default: spr_trig = `SPR_TRIG_3;
      endcase
    end
  endfunction

  reg  [7:0] interrupt_enable;
  reg        fifo_en;
  reg  [1:0] trig_sel;
  reg  [7:0] receive_data;
  reg        rx_full;
  reg  [7:0] transmit_holding;
  reg        thr_full;
  reg        thre_pend;
  reg        rls_pend;
  reg        msi_pend;
  reg  [2:0] cto_cnt;
  reg  [3:0] iir_frozen;
  reg        iir_rd_d;
  reg  [2:0] tx_state;
  reg  [2:0] tx_bitcnt;
  reg  [7:0] tx_shift;
  reg  [2:0] rx_state;
  reg  [2:0] rx_bitcnt;
  reg  [7:0] rx_shift;
  reg  [3:0] iir_live;

  wire sel_lo   = ~divisor_access_bit_in;
  wire rd_data  = rd_in & (addr_in == `SPR_OFS_DATA) & sel_lo;
  wire wr_data  = wr_in & (addr_in == `SPR_OFS_DATA) & sel_lo;
  wire wr_ier   = wr_in & (addr_in == `SPR_OFS_IER) & sel_lo;
  wire rd_iir   = rd_in & (addr_in == `SPR_OFS_IIR_FCR);
  wire wr_fcr   = wr_in & (addr_in == `SPR_OFS_IIR_FCR);
  wire rd_lsr   = rd_in & (addr_in == `SPR_OFS_LSR);
  wire rd_msr   = rd_in & (addr_in == `SPR_OFS_MSR);

  assign divisor_low_wr_out  = wr_in & (addr_in == `SPR_OFS_DATA) & ~sel_lo;
  assign divisor_high_wr_out = wr_in & (addr_in == `SPR_OFS_IER) & ~sel_lo;

  wire       rxf_clr = sys_rst_in | (wr_fcr & (~wdata_in[`SPR_FCR_EN] |
                       wdata_in[`SPR_FCR_RXCLR]));
  wire       txf_clr = sys_rst_in | (wr_fcr & (~wdata_in[`SPR_FCR_EN] |
                       wdata_in[`SPR_FCR_TXCLR]));
  wire [7:0] rxf_data;
  wire       rxf_valid;
  wire       rxf_ready;
  wire [2:0] rxf_count;
  wire [7:0] txf_data;
  wire       txf_valid;
  wire       txf_ready;
  wire [2:0] txf_count;
  wire       rx_done;
  wire       tx_take;

  spr_fifo #(
    .WIDTH (`SPR_FIFO_W),
    .DEPTH (`SPR_FIFO_D),
    .AW    (`SPR_FIFO_AW)
  ) u_rxf (
    .clk_in        (clk_in),
    .sys_rst_in    (sys_rst_in),
    .clear_in      (rxf_clr),
    .in_data_in    (rx_shift),
    .in_valid_in   (rx_done & fifo_en),
    .in_ready_out  (rxf_ready),
    .out_data_out  (rxf_data),
    .out_valid_out (rxf_valid),
    .out_ready_in  (rd_data & fifo_en),
    .count_out     (rxf_count)
  );

  spr_fifo #(
    .WIDTH (`SPR_FIFO_W),
    .DEPTH (`SPR_FIFO_D),
    .AW    (`SPR_FIFO_AW)
  ) u_txf (
    .clk_in        (clk_in),
    .sys_rst_in    (sys_rst_in),
    .clear_in      (txf_clr),
    .in_data_in    (wdata_in),
    .in_valid_in   (wr_data & fifo_en),
    .in_ready_out  (txf_ready),
    .out_data_out  (txf_data),
    .out_valid_out (txf_valid),
    .out_ready_in  (tx_take & fifo_en),
    .count_out     (txf_count)
  );

  // Control registers; clears are pulses, never stored
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      interrupt_enable <= `SPR_RST_IER;
      fifo_en          <= 1'b0;
      trig_sel         <= 2'b00;
    end else begin
      if (wr_ier) begin
        interrupt_enable <= wdata_in & `SPR_IER_MASK;
      end
      // enable bit; bits 3..5 ignored; trigger select
      if (wr_fcr) begin
        fifo_en  <= wdata_in[`SPR_FCR_EN];
        trig_sel <= wdata_in[`SPR_FCR_TRIG_HI:`SPR_FCR_TRIG_LO];
      end
    end
  end

  // Transmitter: loads only when idle, sends LSB first
  wire have_tx = fifo_en ? txf_valid : thr_full;
  assign tx_take = (tx_state == ST_IDLE) & bit_tick_in & have_tx;
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      tx_state  <= ST_IDLE;
      tx_bitcnt <= 3'h0;
      tx_shift  <= `SPR_RST_BYTE;
      txd_out   <= 1'b1;
    end else if (bit_tick_in) begin
      case (tx_state)
        ST_IDLE: begin
          if (have_tx) begin
            tx_shift  <= fifo_en ? txf_data : transmit_holding;
            tx_bitcnt <= 3'h0;
            txd_out   <= 1'b0;
            tx_state  <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          txd_out   <= tx_shift[0];
          tx_shift  <= {1'b0, tx_shift[7:1]};
          tx_bitcnt <= tx_bitcnt + 3'h1;
          if (tx_bitcnt == 3'h7) begin
            tx_state <= ST_STOP;
          end
        end
        ST_STOP: begin
          txd_out  <= 1'b1;
          tx_state <= ST_IDLE;
        end
        default: tx_state <= ST_IDLE;
      endcase
    end
  end

  // Receiver: hidden shift register, LSB arrives first
  // Samples once per bit tick; oversampling is the baud neighbour's job
  assign rx_done = bit_tick_in & (rx_state == ST_STOP) & rxd_in;
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      rx_state  <= ST_IDLE;
      rx_bitcnt <= 3'h0;
      rx_shift  <= `SPR_RST_BYTE;
    end else if (bit_tick_in) begin
      case (rx_state)
        ST_IDLE: begin
          if (!rxd_in) begin
            rx_bitcnt <= 3'h0;
            rx_state  <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          // shift in from the top, so bit 0, received first, ends at LSB
          rx_shift  <= {rxd_in, rx_shift[7:1]};
          rx_bitcnt <= rx_bitcnt + 3'h1;
          if (rx_bitcnt == 3'h7) begin
            rx_state <= ST_STOP;
          end
        end
        ST_STOP: rx_state <= ST_IDLE;
        default: rx_state <= ST_IDLE;
      endcase
    end
  end

  // Holding registers and pending flags; set wins over clear
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      receive_data     <= `SPR_RST_BYTE;
      rx_full          <= 1'b0;
      transmit_holding <= `SPR_RST_BYTE;
      thr_full         <= 1'b0;
      thre_pend        <= 1'b0;
      rls_pend         <= 1'b0;
      msi_pend         <= 1'b0;
    end else begin
      // parallel word moves to receive data
      if (rx_done && !fifo_en) begin
        receive_data <= rx_shift;
        rx_full      <= 1'b1;
      end else if (rd_data || !fifo_en && wr_fcr) begin
        rx_full <= 1'b0;
      end
      if (wr_data && !fifo_en) begin
        transmit_holding <= wdata_in;
        thr_full         <= 1'b1;
      end else if (tx_take && !fifo_en) begin
        thr_full <= 1'b0;
      end
      // transmit empty cleared by write or by naming read
      if (spr_thr_empty(tx_take, fifo_en, txf_count)) begin
        thre_pend <= 1'b1;
      end else if (wr_data ||
                   (rd_iir && !iir_rd_d && iir_live == `SPR_ID_THRE)) begin
        thre_pend <= 1'b0;
      end
      // line errors; cleared by line status read
      if (line_error_in) begin
        rls_pend <= 1'b1;
      end else if (rd_lsr) begin
        rls_pend <= 1'b0;
      end
      // modem change; cleared by modem status read
      if (modem_change_in) begin
        msi_pend <= 1'b1;
      end else if (rd_msr) begin
        msi_pend <= 1'b0;
      end
    end
  end

  // Holding side empties when a byte leaves and nothing stays queued
  function spr_thr_empty;
    input       take;
    input       fifo_mode;
    input [2:0] level;
    begin
      spr_thr_empty = take & (~fifo_mode | (level == 3'h1));
    end
  endfunction

  // character timeout, four quiet char times with data held
  wire rx_activity = rx_done | rd_data;
  always @(posedge clk_in) begin
    if (sys_rst_in || !fifo_en || !rxf_valid || rx_activity) begin
      cto_cnt <= 3'h0;
    end else if (char_tick_in && cto_cnt != `SPR_CTO_CHARS) begin
      cto_cnt <= cto_cnt + 3'h1;
    end
  end

  // data available clears when below trigger or on read
  wire rda_src = fifo_en ? ({2'b00, rxf_count} >= spr_trig(trig_sel)) :
                 rx_full;
  wire cto_src = fifo_en & (cto_cnt == `SPR_CTO_CHARS);

  // fixed priority; gated by enables; codes
  always @* begin
    if (rls_pend && interrupt_enable[`SPR_IER_RLS]) begin
      iir_live = `SPR_ID_RLS;
    end else if (rda_src && interrupt_enable[`SPR_IER_RDA]) begin
      iir_live = `SPR_ID_RDA;
    end else if (cto_src && interrupt_enable[`SPR_IER_RDA]) begin
      iir_live = `SPR_ID_CTO;
    end else if (thre_pend && interrupt_enable[`SPR_IER_THRE]) begin
      iir_live = `SPR_ID_THRE;
    end else if (msi_pend && interrupt_enable[`SPR_IER_MSI]) begin
      iir_live = `SPR_ID_MSI;
    end else begin
      iir_live = `SPR_ID_NONE;
    end
  end

  // capture at start of a read, hold while rd_in stays high
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      iir_rd_d   <= 1'b0;
      iir_frozen <= `SPR_ID_NONE;
    end else begin
      iir_rd_d <= rd_iir;
      if (rd_iir && !iir_rd_d) begin
        iir_frozen <= iir_live;
      end
    end
  end

  // pending output; driven only with output two set
  assign irq_out    = ~iir_live[0];
  assign irq_oe_out = irq_output_gate_in;

  // read decode; identification bits 7..6 follow FIFO enable, bits 5..4 fixed zero
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      rdata_out <= 8'h00;
    end else if (rd_in) begin
      if (addr_in == `SPR_OFS_DATA && !sel_lo) begin
        rdata_out <= divisor_low_in;
      end else if (addr_in == `SPR_OFS_IER && !sel_lo) begin
        rdata_out <= divisor_high_in;
      end else if (addr_in == `SPR_OFS_DATA) begin
        rdata_out <= fifo_en ? rxf_data : receive_data;
      end else if (addr_in == `SPR_OFS_IER) begin
        rdata_out <= interrupt_enable;
      end else if (addr_in == `SPR_OFS_IIR_FCR) begin
        rdata_out <= {fifo_en, fifo_en, 2'b00,
                      iir_rd_d ? iir_frozen : iir_live};
      end else begin
        rdata_out <= aux_rdata_in;
      end
    end
  end

endmodule

// ### spr_regs_props.sv
// Port checks for the serial port register block.
// Assumes only the ports of spr_regs; bound at the foot.
`timescale 1ns/1ps
module spr_regs_props (
  // Clock, reset, bus
  input wire       clk_in,
  input wire       sys_rst_in,
  input wire [2:0] addr_in,
  input wire       rd_in,
  input wire       wr_in,
  input wire [7:0] wdata_in,
  input wire [7:0] rdata_out,
  // Control and outputs
  input wire       divisor_access_bit_in,
  input wire       irq_output_gate_in,
  input wire       divisor_low_wr_out,
  input wire       divisor_high_wr_out,
  input wire       irq_out,
  input wire       irq_oe_out
);
  reg [3:0] ier_q;
  reg       fen_q;
  // Shadow of enables and FIFO mode, since neither is a port
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      ier_q <= 4'h0;
      fen_q <= 1'b0;
    end else if (wr_in) begin
      if (addr_in == 3'h1 && !divisor_access_bit_in)
        ier_q <= wdata_in[3:0];
      if (addr_in == 3'h2)
        fen_q <= wdata_in[0];
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  sequence iir_first;
    rd_in && addr_in == 3'h2 && !$past(rd_in);
  endsequence
  sequence iir_held;
    rd_in && addr_in == 3'h2 && $past(rd_in) && $past(addr_in) == 3'h2;
  endsequence
  div_low_a: assert property (
    divisor_low_wr_out == (wr_in && addr_in == 3'h0 && divisor_access_bit_in))
    else $error("divisor low strobe wrong");
  div_high_a: assert property (
    divisor_high_wr_out == (wr_in && addr_in == 3'h1 && divisor_access_bit_in))
    else $error("divisor high strobe wrong");
  irq_gate_a: assert property (irq_oe_out == irq_output_gate_in)
    else $error("interrupt enable pin wrong");
  ier_read_a: assert property (
    rd_in && addr_in == 3'h1 && !divisor_access_bit_in
    |=> rdata_out == {4'h0, ier_q}) else $error("enable readback wrong");
  irq_off_a: assert property (ier_q == 4'h0 |-> !irq_out)
    else $error("interrupt with all enables clear");
  iir_pend_a: assert property (iir_first ##0 irq_out |=> !rdata_out[0])
    else $error("pending bit wrong");
  iir_none_a: assert property (
    iir_first ##0 !irq_out |=> rdata_out[3:0] == 4'h1)
    else $error("idle code wrong");
  iir_upper_a: assert property (
    iir_first |=> rdata_out[7:4] == {fen_q, fen_q, 2'b00}
    && (fen_q || !rdata_out[3])) else $error("upper bits wrong");
  iir_freeze_a: assert property (iir_held |=> $stable(rdata_out))
    else $error("identification changed during read");
endmodule
bind spr_regs spr_regs_props u_props (
  .clk_in(clk_in), .sys_rst_in(sys_rst_in), .addr_in(addr_in),
  .rd_in(rd_in), .wr_in(wr_in), .wdata_in(wdata_in),
  .rdata_out(rdata_out), .divisor_access_bit_in(divisor_access_bit_in),
  .irq_output_gate_in(irq_output_gate_in),
  .divisor_low_wr_out(divisor_low_wr_out),
  .divisor_high_wr_out(divisor_high_wr_out),
  .irq_out(irq_out), .irq_oe_out(irq_oe_out));

// ### tb_top.sv
// Self-checking bench for the serial port register block.
// Assumes spr_regs, the line peer and the bound checker are compiled.
`timescale 1ns/1ps
module tb_top;
  reg         clk_in, sys_rst_in, rd_in, wr_in, dab, gate;
  reg         lerr, mchg, btick, ctick;
  reg  [2:0]  addr;
  reg  [7:0]  wdata;
  wire [7:0]  rdata;
  wire        txd, rxd, irq, irq_oe;
  wire [2:0]  got;
  integer     miscompares, checks, cyc, i, t, n;
  spr_regs DUT (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .addr_in(addr),
    .rd_in(rd_in), .wr_in(wr_in), .wdata_in(wdata), .rdata_out(rdata),
    .divisor_access_bit_in(dab), .irq_output_gate_in(gate),
    .divisor_low_in(8'h5A), .divisor_high_in(8'hA5), .aux_rdata_in(8'h3C),
    .line_error_in(lerr), .modem_change_in(mchg), .char_tick_in(ctick),
    .divisor_low_wr_out(), .divisor_high_wr_out(), .rxd_in(rxd),
    .bit_tick_in(btick), .txd_out(txd), .irq_out(irq), .irq_oe_out(irq_oe));
  spr_line_peer peer (
    .clk_in(clk_in), .tick_in(btick), .txd_in(txd), .rxd_out(rxd),
    .got_cnt_out(got));
  // 50 ns clock
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  // Bit every 4 cycles, character every 40
  always @(posedge clk_in) begin
    cyc <= sys_rst_in ? 0 : cyc + 1;
    btick <= (cyc % 4 == 3);
    ctick <= (cyc % 40 == 39);
  end
  function integer lvl(input integer k);
    lvl = (k == 0) ? 1 : (k == 1) ? 4 : (k == 2) ? 8 : 14;
  endfunction
  task chk(input string nm, input [7:0] seen, input [7:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task wr(input [2:0] a, input [7:0] d);
    begin
      @(posedge clk_in);
      addr <= a;
      wdata <= d;
      wr_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
    end
  endtask
  task rdc(input [2:0] a, input [7:0] exp);
    begin
      @(posedge clk_in);
      addr <= a;
      rd_in <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
      @(negedge clk_in);
      chk("rdata", rdata, exp);
      @(posedge clk_in);
    end
  endtask
  task report_and_stop;
    begin
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  // Hang guard, several times the expected run
  initial begin
    repeat (20000) @(posedge clk_in);
    miscompares = miscompares + 1;
    report_and_stop;
  end
  initial begin
    {rd_in, wr_in, dab, gate, lerr, mchg} = 6'h00;
    addr = 3'h0;
    wdata = 8'h00;
    miscompares = 0;
    checks = 0;
    sys_rst_in = 1'b1;
    repeat (12) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    rdc(3'h2, 8'h01);
    chk("irq enable", {7'h00, irq_oe}, 8'h00);
    // Enable readback and divisor decode
    wr(3'h1, 8'hFF);
    rdc(3'h1, 8'h0F);
    dab <= 1'b1;
    rdc(3'h0, 8'h5A);
    rdc(3'h1, 8'hA5);
    rdc(3'h3, 8'h3C);
    wr(3'h1, 8'h00);
    wr(3'h0, 8'h00);
    dab <= 1'b0;
    rdc(3'h1, 8'h0F);
    // Errors arrive during a held read, which must not move
    wr(3'h1, 8'h0D);
    gate <= 1'b1;
    @(posedge clk_in);
    addr <= 3'h2;
    rd_in <= 1'b1;
    lerr <= 1'b1;
    mchg <= 1'b1;
    @(posedge clk_in);
    lerr <= 1'b0;
    mchg <= 1'b0;
    repeat (2) @(posedge clk_in);
    rd_in <= 1'b0;
    @(negedge clk_in);
    chk("frozen", rdata, 8'h01);
    chk("irq", {7'h00, irq}, 8'h01);
    chk("irq enable", {7'h00, irq_oe}, 8'h01);
    rdc(3'h2, 8'h06);
    rdc(3'h5, 8'h3C);
    rdc(3'h2, 8'h00);
    rdc(3'h6, 8'h3C);
    rdc(3'h2, 8'h01);
    // Second byte written once the first has reached the shifter
    wr(3'h1, 8'h02);
    wr(3'h0, 8'h3C);
    repeat (8) @(posedge clk_in);
    wr(3'h0, 8'hC3);
    for (i = 0; i < 2000 && got != 3'h2; i = i + 1)
      @(posedge clk_in);
    chk("tx0", peer.got[0], 8'h3C);
    chk("tx1", peer.got[1], 8'hC3);
    rdc(3'h2, 8'h02);
    rdc(3'h2, 8'h01);
    // One byte received without FIFOs
    wr(3'h1, 8'h01);
    peer.send(8'h96);
    repeat (12) @(posedge clk_in);
    rdc(3'h2, 8'h04);
    rdc(3'h0, 8'h96);
    rdc(3'h2, 8'h01);
    // Every trigger level, filling one byte at a time
    for (t = 0; t < 4; t = t + 1) begin
      // enable bit written with the other bits
      wr(3'h2, {t[1:0], 6'h03});
      for (n = 1; n < 5; n = n + 1) begin
        peer.send(n[7:0]);
        repeat (12) @(posedge clk_in);
        rdc(3'h2, (n >= lvl(t)) ? 8'hC4 : 8'hC1);
      end
      if (t == 1) begin
        rdc(3'h0, 8'h01);
        rdc(3'h2, 8'hC1);
      end
    end
    wr(3'h2, 8'hC3);
    repeat (250) @(posedge clk_in);
    rdc(3'h2, 8'hC1);
    wr(3'h2, 8'hF9);
    rdc(3'h2, 8'hC1);
    peer.send(8'hAB);
    repeat (250) @(posedge clk_in);
    rdc(3'h2, 8'hCC);
    rdc(3'h0, 8'hAB);
    rdc(3'h2, 8'hC1);
    // Leaving FIFO mode drops what is queued
    peer.send(8'h11);
    repeat (12) @(posedge clk_in);
    wr(3'h2, 8'h00);
    rdc(3'h2, 8'h01);
    // Re-enabling without a clear must find the receive FIFO empty
    wr(3'h2, 8'h01);
    rdc(3'h2, 8'hC1);
    // Queued bytes go on a transmit clear; the shifter keeps its byte
    wr(3'h0, 8'hA1);
    wr(3'h0, 8'hA2);
    wr(3'h0, 8'hA3);
    wr(3'h2, 8'h05);
    repeat (200) @(posedge clk_in);
    chk("tx frames", {5'h00, got}, 8'h03);
    chk("tx kept", peer.got[2], 8'hA1);
    report_and_stop;
  end
endmodule
